// ===== rtl/mief_pkg.sv
// Operation
// - Flags set on events regardless of enables
// - Clear flags before enabling a source
// - Global enable bit 7 gates all requests
// - Group enable bit 6 gates peripherals
// - Timer0, pin, change enables at 5,4,3
// - Pin change also needs per-pin enables
// - Timer0 rollover sets bit 2, sticky
// - Software loads Timer0 before clearing flag
// - Selected pin edge sets bit 1, sticky
// - Edge select: one rising, zero falling
// - Any of six pins with its change enable set changing sets bit 0
// - Peripheral enables at bits 6,5,3,1,0
// - Peripherals need the group enable
// - Bits 7,4,2 of peripheral registers read zero
// - Conversion done sets ADC flag bit 6
// - Capture or compare sets bit 5, not PWM
// - Comparator output change sets bit 3
// - Timer2 period match sets bit 1
// - Timer1 overflow sets bit 0
// - Reduced variant drops ADC, capcomp, Timer2 bits
// - Taken interrupt pushes program counter
// - Return pops counter, high latch untouched
package mief_pkg;

    // Interrupt control register fields
    localparam int unsigned GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int unsigned PERIPH_GROUP_ENABLE_BIT = 6;
    localparam int unsigned TIMER_ZERO_ENABLE_BIT = 5;
    localparam int unsigned EXT_PIN_ENABLE_BIT = 4;
    localparam int unsigned PIN_CHANGE_ENABLE_BIT = 3;
    localparam int unsigned TIMER_ZERO_FLAG_BIT = 2;
    localparam int unsigned EXT_PIN_FLAG_BIT = 1;
    localparam int unsigned PIN_CHANGE_FLAG_BIT = 0;

    // Peripheral enable and flag bits, shared layout
    localparam int unsigned ADC_BIT = 6;
    localparam int unsigned CAPCOMP_BIT = 5;
    localparam int unsigned COMPARATOR_BIT = 3;
    localparam int unsigned TIMER_TWO_BIT = 1;
    localparam int unsigned TIMER_ONE_BIT = 0;

    // Implemented peripheral bits; the rest read as zero
    localparam logic [7:0] PERIPH_MASK_FULL = 8'h6b;
    localparam logic [7:0] PERIPH_MASK_REDUCED = 8'h09;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Register select codes on the link
    localparam logic [1:0] SEL_INTERRUPT_CONTROL = 2'h0;
    localparam logic [1:0] SEL_PERIPH_ENABLE = 2'h1;
    localparam logic [1:0] SEL_PERIPH_FLAGS = 2'h2;

    // Return stack geometry and port pin count
    localparam int unsigned PC_W = 13;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned SP_W = 3;
    localparam int unsigned GPIO_W = 6;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [SP_W-1:0] SP_STEP = 3'h1;

    // Capture/compare operating modes
    typedef enum logic [1:0] {
        MIEF_CCP_OFF,
        MIEF_CCP_CAPTURE,
        MIEF_CCP_COMPARE,
        MIEF_CCP_PWM
    } mief_ccp_mode_e;

    // Wishbone map of the controller, byte addresses
    localparam logic [7:0] WB_DATA = 8'h00;
    localparam logic [7:0] WB_CMD = 8'h04;
    localparam logic [7:0] WB_PC = 8'h08;
    localparam logic [7:0] WB_STATUS = 8'h0c;

    // Command word fields
    localparam int unsigned CMD_SEL_LO = 0;
    localparam int unsigned CMD_WRITE_BIT = 4;
    localparam int unsigned CMD_READ_BIT = 5;
    localparam int unsigned CMD_TAKE_BIT = 6;
    localparam int unsigned CMD_RETURN_BIT = 7;

    // Status word fields
    localparam int unsigned ST_IRQ_BIT = 8;
    localparam int unsigned ST_VALID_BIT = 9;
    localparam int unsigned ST_PC_LO = 16;

endpackage

// ===== rtl/mief_if.sv
// Link between the interrupt logic and the processor core
interface mief_if (
    input wire logic ref_clk,
    input wire logic sys_rst
);
    logic [1:0] reg_sel; // Register select
    logic reg_wr; // One-cycle write strobe
    logic reg_rd; // One-cycle read strobe
    logic [7:0] reg_wdata; // Write data
    logic [7:0] reg_rdata; // Read data, valid cycle after reg_rd
    logic irq_req; // Interrupt request level
    logic irq_take; // Core branches to the vector
    logic [mief_pkg::PC_W-1:0] irq_pc; // Counter pushed on take
    logic ret_from_irq; // Return instruction executed
    logic [mief_pkg::PC_W-1:0] ret_pc; // Counter popped on return

    // Documented interrupt logic end
    modport dev (
        input ref_clk, sys_rst, reg_sel, reg_wr, reg_rd, reg_wdata,
        input irq_take, irq_pc, ret_from_irq,
        output reg_rdata, irq_req, ret_pc
    );

    // Core end
    modport core (
        input ref_clk, sys_rst, reg_rdata, irq_req, ret_pc,
        output reg_sel, reg_wr, reg_rd, reg_wdata,
        output irq_take, irq_pc, ret_from_irq
    );
endinterface

// ===== rtl/mief_core.sv
// Core end: Wishbone commands turned into link strobes
module mief_core (
    mief_if.core link,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o
);
    logic [7:0] data_reg; // Data for register writes
    logic [mief_pkg::PC_W-1:0] pc_reg; // Counter for the next take
    logic rd_pend; // Read answer arrives this cycle
    logic rd_valid; // Captured read data is fresh
    logic [7:0] rdata_cap; // Last register read result
    logic wr_hit; // Write accepted at this edge
    logic cmd_hit; // Command word written with lane 0
    logic [31:0] next_dat; // Read mux

    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign cmd_hit = wr_hit && (wb_adr_i == mief_pkg::WB_CMD) && wb_sel_i[0];

    // Ack a cycle after the request, dropped the next
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read mux; unmapped addresses answer zero
    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            mief_pkg::WB_DATA: next_dat[7:0] = data_reg;
            mief_pkg::WB_PC: next_dat[mief_pkg::PC_W-1:0] = pc_reg;
            mief_pkg::WB_STATUS: begin
                next_dat[7:0] = rdata_cap;
                next_dat[mief_pkg::ST_IRQ_BIT] = link.irq_req;
                next_dat[mief_pkg::ST_VALID_BIT] = rd_valid;
                next_dat[mief_pkg::ST_PC_LO +: mief_pkg::PC_W] = link.ret_pc;
            end
            default: next_dat = 32'h0000_0000;
        endcase
    end

    // Read data loaded together with the ack
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= next_dat;
        end
    end

    // Data and counter registers, byte lanes honoured
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            data_reg <= mief_pkg::REG_RESET;
            pc_reg <= mief_pkg::PC_RESET;
        end else if (wr_hit) begin
            if (wb_adr_i == mief_pkg::WB_DATA && wb_sel_i[0]) begin
                data_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == mief_pkg::WB_PC) begin
                if (wb_sel_i[0]) begin
                    pc_reg[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    pc_reg[mief_pkg::PC_W-1:8] <= wb_dat_i[mief_pkg::PC_W-1:8];
                end
            end
        end
    end

    // One-cycle command strobes after the accepting edge
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            link.reg_sel <= mief_pkg::SEL_INTERRUPT_CONTROL;
            link.reg_wdata <= mief_pkg::REG_RESET;
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.irq_take <= 1'b0;
            link.irq_pc <= mief_pkg::PC_RESET;
            link.ret_from_irq <= 1'b0;
        end else begin
            link.reg_wr <= cmd_hit && wb_dat_i[mief_pkg::CMD_WRITE_BIT];
            link.reg_rd <= cmd_hit && wb_dat_i[mief_pkg::CMD_READ_BIT];
            link.irq_take <= cmd_hit && wb_dat_i[mief_pkg::CMD_TAKE_BIT];
            link.ret_from_irq <= cmd_hit && wb_dat_i[mief_pkg::CMD_RETURN_BIT];
            if (cmd_hit) begin
                link.reg_sel <= wb_dat_i[mief_pkg::CMD_SEL_LO +: 2];
                link.reg_wdata <= data_reg;
                link.irq_pc <= pc_reg;
            end
        end
    end

    // Read answer captured a cycle after the strobe
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            rd_pend <= 1'b0;
            rd_valid <= 1'b0;
            rdata_cap <= mief_pkg::REG_RESET;
        end else begin
            rd_pend <= link.reg_rd;
            if (rd_pend) begin
                rdata_cap <= link.reg_rdata;
                rd_valid <= 1'b1;
            end else if (link.reg_rd) begin
                rd_valid <= 1'b0;
            end
        end
    end
endmodule // mief_core

// ===== rtl/mief_dev.sv
// Interrupt enable and flag logic with the hardware return stack
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
module mief_dev #(
    parameter bit FULL_VARIANT = 1'b1 // Zero drops ADC, capcomp, Timer2
) (
    mief_if.dev link,
    input wire logic ext_pin_in, // External interrupt pin, async
    input wire logic [mief_pkg::GPIO_W-1:0] gpio_pins, // Port pins, async
    input wire logic [mief_pkg::GPIO_W-1:0] per_pin_change_enables,
    input wire logic ext_pin_edge_select, // 1 rising, 0 falling
    input wire logic timer_zero_rollover, // Pulse from Timer0
    input wire logic adc_done, // Conversion complete pulse
    input wire logic capcomp_capture, // Capture pulse
    input wire logic capcomp_compare, // Compare match pulse
    input wire logic [1:0] capcomp_mode, // Capture/compare mode
    input wire logic comparator_out, // Comparator output, async
    input wire logic timer_two_match, // Timer2 period match pulse
    input wire logic timer_one_overflow // Timer1 overflow pulse
);
    // Implemented peripheral bits for this variant
    localparam logic [7:0] PERIPH_MASK = FULL_VARIANT ?
        mief_pkg::PERIPH_MASK_FULL : mief_pkg::PERIPH_MASK_REDUCED;

    logic [7:0] interrupt_control; // Enables and core flags
    logic [7:0] peripheral_interrupt_enable; // Peripheral enables
    logic [7:0] peripheral_interrupt_flags; // Peripheral flags
    logic [7:0] next_interrupt_control;
    logic [7:0] next_peripheral_interrupt_flags;
    logic [7:0] core_events; // Set pulses for core flags
    logic [7:0] periph_events; // Set pulses for peripheral flags

    // Async inputs as one vector: {comparator, pin, port}
    localparam int unsigned EXT_IDX = mief_pkg::GPIO_W;
    localparam int unsigned CMP_IDX = mief_pkg::GPIO_W + 1;
    logic [CMP_IDX:0] pin_meta, pin_sync, pin_prev;
    logic [1:0] prime_shift; // Edges seen since reset
    logic sync_primed; // Previous samples hold real data

    logic ext_edge; // Selected edge seen on the pin
    logic pin_change; // Enabled pin changed state
    logic cmp_change; // Comparator output toggled
    logic capcomp_event; // Capture or compare per mode

    // Return stack storage
    logic [mief_pkg::PC_W-1:0] stack_mem [mief_pkg::STACK_DEPTH];
    logic [mief_pkg::SP_W-1:0] stack_ptr; // Next slot to push
    logic [mief_pkg::PC_W-1:0] ret_pc_q; // Popped counter

    // Register strobes decoded from the link
    logic wr_control, wr_enable, wr_flags;
    assign wr_control = link.reg_wr &&
        link.reg_sel == mief_pkg::SEL_INTERRUPT_CONTROL;
    assign wr_enable = link.reg_wr &&
        link.reg_sel == mief_pkg::SEL_PERIPH_ENABLE;
    assign wr_flags = link.reg_wr &&
        link.reg_sel == mief_pkg::SEL_PERIPH_FLAGS;

    // Two-flop synchronisers; logic reads the second stage only
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {comparator_out, ext_pin_in, gpio_pins};
            pin_sync <= pin_meta;
        end
    end

    // Previous samples; compares wait three edges, so an idle-high
    // pin is not taken for an edge while the chain fills after reset
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            pin_prev <= '0;
            prime_shift <= '0;
            sync_primed <= 1'b0;
        end else begin
            pin_prev <= pin_sync;
            prime_shift <= {prime_shift[0], 1'b1};
            sync_primed <= prime_shift[1];
        end
    end

    // Edge and change detection
    always_comb begin
        // Edge: pin changed and now stands at the selected level
        ext_edge = sync_primed && pin_sync[EXT_IDX] != pin_prev[EXT_IDX] &&
            pin_sync[EXT_IDX] == ext_pin_edge_select;
        // Only port pins with their own change enable count
        pin_change = sync_primed && |((pin_sync[EXT_IDX-1:0] ^
            pin_prev[EXT_IDX-1:0]) & per_pin_change_enables);
        cmp_change = sync_primed &&
            pin_sync[CMP_IDX] != pin_prev[CMP_IDX];
        // PWM and off modes never raise the capcomp flag
        case (mief_pkg::mief_ccp_mode_e'(capcomp_mode))
            mief_pkg::MIEF_CCP_CAPTURE: capcomp_event = capcomp_capture;
            mief_pkg::MIEF_CCP_COMPARE: capcomp_event = capcomp_compare;
            default: capcomp_event = 1'b0;
        endcase
    end

    // Event vectors; enables play no part here
    always_comb begin
        core_events = 8'h00;
        core_events[mief_pkg::TIMER_ZERO_FLAG_BIT] = timer_zero_rollover;
        core_events[mief_pkg::EXT_PIN_FLAG_BIT] = ext_edge;
        core_events[mief_pkg::PIN_CHANGE_FLAG_BIT] = pin_change;
        periph_events = 8'h00;
        periph_events[mief_pkg::ADC_BIT] = adc_done;
        periph_events[mief_pkg::CAPCOMP_BIT] = capcomp_event;
        periph_events[mief_pkg::COMPARATOR_BIT] = cmp_change;
        periph_events[mief_pkg::TIMER_TWO_BIT] = timer_two_match;
        periph_events[mief_pkg::TIMER_ONE_BIT] = timer_one_overflow;
    end

    // Control next value; hardware set beats software clear
    always_comb begin
        next_interrupt_control = interrupt_control;
        if (wr_control) begin
            next_interrupt_control = link.reg_wdata;
        end
        // Vectoring masks further requests until the return
        if (link.irq_take) begin
            next_interrupt_control[mief_pkg::GLOBAL_IRQ_ENABLE_BIT] = 1'b0;
        end else if (link.ret_from_irq) begin
            next_interrupt_control[mief_pkg::GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
        end
        next_interrupt_control = next_interrupt_control | core_events;
    end

    // Interrupt control register
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            interrupt_control <= mief_pkg::REG_RESET;
        end else begin
            interrupt_control <= next_interrupt_control;
        end
    end

    // Peripheral enables; unimplemented bits never store
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            peripheral_interrupt_enable <= mief_pkg::REG_RESET;
        end else if (wr_enable) begin
            peripheral_interrupt_enable <= link.reg_wdata & PERIPH_MASK;
        end
    end

    // Flag next value: set beats clear, masked to variant
    always_comb begin
        next_peripheral_interrupt_flags = peripheral_interrupt_flags;
        if (wr_flags) begin
            next_peripheral_interrupt_flags = link.reg_wdata;
        end
        next_peripheral_interrupt_flags =
            (next_peripheral_interrupt_flags | periph_events) & PERIPH_MASK;
    end

    // Peripheral flag register
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            peripheral_interrupt_flags <= mief_pkg::REG_RESET;
        end else begin
            peripheral_interrupt_flags <= next_peripheral_interrupt_flags;
        end
    end

    // Request: global gate over core pairs and gated peripheral pairs
    always_comb begin
        link.irq_req = interrupt_control[mief_pkg::GLOBAL_IRQ_ENABLE_BIT] && (
            (interrupt_control[mief_pkg::TIMER_ZERO_ENABLE_BIT] &&
             interrupt_control[mief_pkg::TIMER_ZERO_FLAG_BIT]) ||
            (interrupt_control[mief_pkg::EXT_PIN_ENABLE_BIT] &&
             interrupt_control[mief_pkg::EXT_PIN_FLAG_BIT]) ||
            (interrupt_control[mief_pkg::PIN_CHANGE_ENABLE_BIT] &&
             interrupt_control[mief_pkg::PIN_CHANGE_FLAG_BIT]) ||
            (interrupt_control[mief_pkg::PERIPH_GROUP_ENABLE_BIT] &&
             |(peripheral_interrupt_enable & peripheral_interrupt_flags))
        );
    end

    // Read answer, one cycle after the strobe
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            link.reg_rdata <= mief_pkg::REG_RESET;
        end else if (link.reg_rd) begin
            case (link.reg_sel)
                mief_pkg::SEL_INTERRUPT_CONTROL:
                    link.reg_rdata <= interrupt_control;
                mief_pkg::SEL_PERIPH_ENABLE:
                    link.reg_rdata <= peripheral_interrupt_enable;
                mief_pkg::SEL_PERIPH_FLAGS:
                    link.reg_rdata <= peripheral_interrupt_flags;
                default: link.reg_rdata <= mief_pkg::REG_RESET;
            endcase
        end
    end

    // Circular return stack; no overflow indication, wrap overwrites.
    // Push wins if take and return arrive together.
    always_ff @(posedge link.ref_clk) begin
        if (link.sys_rst) begin
            stack_ptr <= mief_pkg::SP_RESET;
            ret_pc_q <= mief_pkg::PC_RESET;
        end else if (link.irq_take) begin
            stack_ptr <= stack_ptr + mief_pkg::SP_STEP;
        end else if (link.ret_from_irq) begin
            stack_ptr <= stack_ptr - mief_pkg::SP_STEP;
            ret_pc_q <= stack_mem[stack_ptr - mief_pkg::SP_STEP];
        end
    end

    // Stack storage is data only and needs no reset
    always_ff @(posedge link.ref_clk) begin
        if (link.irq_take) begin
            stack_mem[stack_ptr] <= link.irq_pc;
        end
    end

    // High latch lives elsewhere; a pop never touches it
    assign link.ret_pc = ret_pc_q;
endmodule // mief_dev

// ===== dv/mief_asserts.sv
// Link watcher; shadows enables to judge requests
module mief_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [1:0] reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_req,
    input wire logic irq_take,
    input wire logic [mief_pkg::PC_W-1:0] irq_pc,
    input wire logic ret_from_irq,
    input wire logic [mief_pkg::PC_W-1:0] ret_pc
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    localparam logic [1:0] S_CTL = mief_pkg::SEL_INTERRUPT_CONTROL;
    localparam logic [1:0] S_PE = mief_pkg::SEL_PERIPH_ENABLE;
    localparam logic [1:0] S_PF = mief_pkg::SEL_PERIPH_FLAGS;
    localparam logic [7:0] PE_M = mief_pkg::PERIPH_MASK_FULL;
    logic [7:0] ctl_sh; // Expected control enables
    logic [7:0] pe_sh; // Expected peripheral enables
    logic [mief_pkg::PC_W-1:0] last_pc; // Latest push
    logic pushed; // Push not yet popped
    logic gate_ok; // Some enable path open
    // Control shadow; take clears global enable, return sets it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctl_sh <= 8'h00;
        end else if (reg_wr && reg_sel == S_CTL) begin
            ctl_sh <= reg_wdata;
        end else if (irq_take) begin
            ctl_sh[7] <= 1'b0;
        end else if (ret_from_irq) begin
            ctl_sh[7] <= 1'b1;
        end
    end
    // Peripheral enable shadow
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pe_sh <= 8'h00;
        end else if (reg_wr && reg_sel == S_PE) begin
            pe_sh <= reg_wdata;
        end
    end
    // Top entry only; deeper pops are judged by the bench
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pushed <= 1'b0;
        end else if (irq_take) begin
            pushed <= 1'b1;
            last_pc <= irq_pc;
        end else if (ret_from_irq) begin
            pushed <= 1'b0;
        end
    end
    assign gate_ok = ctl_sh[7] && (ctl_sh[5:3] != 3'h0 ||
        (ctl_sh[6] && (pe_sh & PE_M) != 8'h00));
    property p_rd_pe;
        reg_rd && reg_sel == S_PE |=> reg_rdata == (pe_sh & PE_M);
    endproperty
    a_rd_pe: assert property (p_rd_pe)
        else $error("enable readback wrong");
    property p_rd_pf;
        reg_rd && reg_sel == S_PF |=> (reg_rdata & 8'h94) == 8'h00;
    endproperty
    a_rd_pf: assert property (p_rd_pf)
        else $error("unused flag bit set");
    property p_rd_ctl;
        reg_rd && reg_sel == S_CTL |=> reg_rdata[7:3] == ctl_sh[7:3];
    endproperty
    a_rd_ctl: assert property (p_rd_ctl)
        else $error("control readback wrong");
    property p_gate;
        irq_req |-> gate_ok;
    endproperty
    a_gate: assert property (p_gate)
        else $error("request with gates shut");
    property p_take;
        irq_take |=> !irq_req;
    endproperty
    a_take: assert property (p_take)
        else $error("request after take");
    property p_pop;
        ret_from_irq && !irq_take && pushed |=> ret_pc == last_pc;
    endproperty
    a_pop: assert property (p_pop)
        else $error("pop differs from push");
    property p_hold;
        !ret_from_irq |=> $stable(ret_pc);
    endproperty
    a_hold: assert property (p_hold)
        else $error("return counter moved");
    property p_both;
        irq_take && ret_from_irq |=> $stable(ret_pc);
    endproperty
    a_both: assert property (p_both)
        else $error("take with return popped");
    c_irq: cover property (irq_req);
    c_take: cover property (irq_take);
    c_pop: cover property (ret_from_irq && pushed);
    c_pf: cover property (reg_rd && reg_sel == S_PF);
endmodule // mief_asserts

// ===== dv/tb_top.sv
// Bench: Wishbone driver notes expectations, monitor compares
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] CTL = mief_pkg::SEL_INTERRUPT_CONTROL;
    localparam logic [1:0] PE = mief_pkg::SEL_PERIPH_ENABLE;
    localparam logic [1:0] PF = mief_pkg::SEL_PERIPH_FLAGS;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] adr = 8'h00; // Wishbone request
    logic [31:0] dat = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic [31:0] dat_o;
    logic ack;
    logic ext_pin = 1'b0; // Pins and events to the device
    logic [5:0] gpio = 6'h00;
    logic [5:0] ppce = 6'h00;
    logic edge_sel = 1'b1;
    logic [5:0] ev = 6'h00;
    logic [1:0] ccmode = 2'h1;
    logic cmp = 1'b0;
    logic [31:0] exp_q[$]; // Expected status words
    logic [31:0] msk_q[$];
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] v;
    logic [12:0] pa, pb;
    // Free running core clock
    initial forever #4 ref_clk = ~ref_clk;
    mief_if mief_if_i (.ref_clk(ref_clk), .sys_rst(sys_rst));
    mief_core mief_core_i (.link(mief_if_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hf), .wb_stb_i(cyc),
        .wb_cyc_i(cyc), .wb_ack_o(ack));
    mief_dev #(.FULL_VARIANT(1'b1)) mief_dev_i (.link(mief_if_i),
        .ext_pin_in(ext_pin), .gpio_pins(gpio), .per_pin_change_enables(ppce),
        .ext_pin_edge_select(edge_sel), .timer_zero_rollover(ev[0]),
        .adc_done(ev[1]), .capcomp_capture(ev[2]), .capcomp_compare(ev[3]),
        .capcomp_mode(ccmode), .comparator_out(cmp),
        .timer_two_match(ev[4]), .timer_one_overflow(ev[5]));
    mief_asserts mief_asserts_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_sel(mief_if_i.reg_sel), .reg_wr(mief_if_i.reg_wr),
        .reg_rd(mief_if_i.reg_rd), .reg_wdata(mief_if_i.reg_wdata),
        .reg_rdata(mief_if_i.reg_rdata), .irq_req(mief_if_i.irq_req),
        .irq_take(mief_if_i.irq_take), .irq_pc(mief_if_i.irq_pc),
        .ret_from_irq(mief_if_i.ret_from_irq), .ret_pc(mief_if_i.ret_pc));
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    // One classic cycle, held until ack; only the hang limit ends it
    task automatic wb(input logic [7:0] a, input logic [31:0] d,
        input logic w);
        @(posedge ref_clk);
        cyc <= 1'b1;
        adr <= a;
        dat <= d;
        we <= w;
        do @(posedge ref_clk); while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic wr_reg(input logic [1:0] s, input logic [7:0] val);
        wb(mief_pkg::WB_DATA, {24'h0, val}, 1'b1);
        wb(mief_pkg::WB_CMD, {26'h0, 4'h4, s}, 1'b1);
    endtask
    // Status settles three cycles after the command ack
    task automatic stat(input logic [31:0] e, input logic [31:0] m);
        repeat (3) @(posedge ref_clk);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb(mief_pkg::WB_STATUS, 32'h0, 1'b0);
    endtask
    task automatic rd_reg(input logic [1:0] s, input logic [7:0] e);
        wb(mief_pkg::WB_CMD, {26'h0, 4'h8, s}, 1'b1);
        stat({22'h0, 2'b10, e}, 32'h2ff);
    endtask
    task automatic irq(input logic e);
        stat({23'h0, e, 8'h0}, 32'h100);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge ref_clk);
        ev <= m;
        @(posedge ref_clk);
        ev <= 6'h00;
    endtask
    // Monitor: read acks take the oldest note; hang limit
    always @(posedge ref_clk) begin
        cycles++;
        if (cyc && ack === 1'b1 && !we) begin
            check(dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
        if (cycles > 8000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'he50dd301));
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int s = 0; s < 3; s++) rd_reg(2'(s), 8'h00);
        v = 8'($urandom());
        wr_reg(PE, v);
        rd_reg(PE, v & mief_pkg::PERIPH_MASK_FULL);
        wr_reg(CTL, v & 8'hf8);
        rd_reg(CTL, v & 8'hf8);
        wr_reg(CTL, 8'h00);
        wr_reg(PE, 8'h00);
        $display("test reset and enables done");
        // Every source fires with interrupt enables off; only pin 2 has its change enable set
        ppce <= 6'h04;
        pulse(6'h3f);
        cmp <= 1'b1;
        ext_pin <= 1'b1;
        gpio <= 6'h04;
        repeat (8) @(posedge ref_clk);
        rd_reg(PF, 8'h6b);
        rd_reg(CTL, 8'h07);
        irq(1'b0);
        // Group and global gating
        wr_reg(CTL, 8'h00);
        wr_reg(PE, 8'h6b);
        wr_reg(CTL, 8'h80);
        irq(1'b0);
        wr_reg(CTL, 8'h40);
        irq(1'b0);
        wr_reg(CTL, 8'hc0);
        irq(1'b1);
        wr_reg(PE, 8'h01);
        wr_reg(PF, 8'h6a);
        irq(1'b0);
        wr_reg(PE, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr_reg(CTL, 8'h80 | (8'h04 >> i));
            irq(1'b0);
            wr_reg(CTL, 8'h80 | (8'h04 >> i) | (8'h20 >> i));
            irq(1'b1);
        end
        $display("test gating done");
        // Falling edge selected; unenabled pin change ignored
        edge_sel <= 1'b0;
        repeat (8) @(posedge ref_clk);
        wr_reg(CTL, 8'h00);
        ext_pin <= 1'b0;
        gpio <= 6'h05;
        repeat (8) @(posedge ref_clk);
        rd_reg(CTL, 8'h02);
        wr_reg(CTL, 8'h00);
        ext_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd_reg(CTL, 8'h00);
        // Capture/compare flag by mode
        wr_reg(PF, 8'h00);
        ccmode <= 2'h3;
        pulse(6'h0c);
        rd_reg(PF, 8'h00);
        ccmode <= 2'h2;
        pulse(6'h08);
        rd_reg(PF, 8'h20);
        $display("test pins and modes done");
        // Two pushes, the second beside a return, two pops
        pa = 13'($urandom());
        pb = 13'($urandom());
        wb(mief_pkg::WB_PC, {19'h0, pa}, 1'b1);
        wb(mief_pkg::WB_CMD, 32'h40, 1'b1);
        wb(mief_pkg::WB_PC, {19'h0, pb}, 1'b1);
        wb(mief_pkg::WB_CMD, 32'hc0, 1'b1);
        wb(mief_pkg::WB_CMD, 32'h80, 1'b1);
        stat({3'h0, pb, 16'h0}, 32'h1fff0000);
        wb(mief_pkg::WB_CMD, 32'h80, 1'b1);
        stat({3'h0, pa, 16'h0}, 32'h1fff0000);
        $display("test stack done");
        finish_test();
    end
endmodule // tb_top
